/* File: tsc_regs.sv */
`timescale 1ns/1ps
// Touch sensor control register bank
module tsc_regs
  import tsc_pkg::*;
#(
  parameter bit FOUR_CH = 1'b1, // Four-channel variant when set
  parameter int READY_CYCLES = TSC_READY_CYC
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire tsc_conv_t CONV0_IN,
  input wire tsc_conv_t CONV1_IN,
  input wire tsc_conv_t CONV2_IN,
  input wire tsc_conv_t CONV3_IN,
  output logic [7:0] RDATA_OUT,
  output logic [3:0] CHAN_ACTIVE_OUT,
  output logic [3:0] CHAN_LOWPWR_OUT,
  output logic CONVERT_EN_OUT,
  output logic CHIP_READY_OUT
);
  tsc_req_t req; // Bundled bus request
  logic [7:0] reset_ctl_q; // Reset/configuration register
  logic [7:0] reset_ctl_d;
  logic [7:0] enable_q; // Channel enable register
  logic [7:0] enable_d;
  logic [7:0] rdata_q; // Read data, valid one cycle after strobe
  logic [7:0] rdata_d;
  logic full_reset_q; // Full reset pulse in progress
  logic chip_ready; // Timer says chip ready
  logic wr_reset; // Write to reset register
  logic wr_enable; // Write to enable register
  logic hold; // Configuration hold
  logic [3:0] chan_en; // Effective channel enables
  logic [3:0] accept; // Per-channel conversion accept
  logic [11:0] res [TSC_NCH]; // Held results
  tsc_conv_t conv [TSC_NCH]; // Conversion inputs as array
  logic [7:0] enable_rd; // Readback of enable register

  assign req = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, wdata: WDATA_IN};
  assign conv[0] = CONV0_IN;
  assign conv[1] = CONV1_IN;
  assign conv[2] = CONV2_IN;
  assign conv[3] = CONV3_IN;

  // Write decode
  assign wr_reset = req.wr && (req.addr == TSC_OFF_RESET);
  assign wr_enable = req.wr && (req.addr == TSC_OFF_ENABLE);

  // Full reset returns all registers to default; the bit self-clears
  assign reset_ctl_d = full_reset_q ? TSC_RST_RESET :
                       wr_reset ? req.wdata : reset_ctl_q;
  assign enable_d = full_reset_q ? TSC_RST_ENABLE :
                    wr_enable ? req.wdata : enable_q;

  // Control registers
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      reset_ctl_q <= TSC_RST_RESET;
      enable_q <= TSC_RST_ENABLE;
      full_reset_q <= 1'b0;
    end else begin
      reset_ctl_q <= reset_ctl_d;
      enable_q <= enable_d;
      // One-cycle internal reset pulse from the written bit
      full_reset_q <= wr_reset && req.wdata[TSC_BIT_FULL_RESET];
    end
  end

  // Chip-ready timer restarted by full reset
  tsc_ready_timer #(
    .CYCLES(READY_CYCLES)
  ) u_ready (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .start_in(full_reset_q),
    .ready_out(chip_ready)
  );

  // Hold bit stops conversions, registers untouched
  assign hold = reset_ctl_q[TSC_BIT_CFG_HOLD];
  // Two-channel variant keeps channels 0,1 always on, 2,3 off
  assign chan_en = FOUR_CH ? enable_q[3:0] : 4'h3;
  // Low-power only where ordinary enable is also set
  assign CHAN_LOWPWR_OUT = enable_q[7:4] & chan_en;
  assign CHAN_ACTIVE_OUT = chan_en;
  // Conversions run only when ready and not held
  assign CONVERT_EN_OUT = chip_ready && !hold && !full_reset_q;
  assign CHIP_READY_OUT = chip_ready;
  assign accept = chan_en & {4{CONVERT_EN_OUT}};

  // Result holders, one per channel
  genvar g;
  generate
    for (g = 0; g < TSC_NCH; g++) begin : g_res
      tsc_result_reg u_res (
        .clk_in(REF_CLK_IN),
        .rstn_in(RSTN_IN),
        .clear_in(full_reset_q),
        .accept_in(accept[g]),
        .conv_in(conv[g]),
        .result_out(res[g])
      );
    end
  endgenerate

  // Enable readback: reserved bits read zero on two-channel variant
  assign enable_rd = FOUR_CH ? enable_q : {enable_q[7:4], 4'h0};

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      TSC_OFF_STATUS: rdata_d = {7'h00, chip_ready};
      TSC_OFF_CH0_LO: rdata_d = res[0][7:0];
      TSC_OFF_CH0_HI: rdata_d = {4'h0, res[0][11:8]};
      TSC_OFF_CH1_LO: rdata_d = res[1][7:0];
      TSC_OFF_CH1_HI: rdata_d = {4'h0, res[1][11:8]};
      TSC_OFF_CH2_LO: rdata_d = res[2][7:0];
      TSC_OFF_CH2_HI: rdata_d = {4'h0, res[2][11:8]};
      TSC_OFF_CH3_LO: rdata_d = res[3][7:0];
      TSC_OFF_CH3_HI: rdata_d = {4'h0, res[3][11:8]};
      TSC_OFF_RESET: rdata_d = reset_ctl_q;
      TSC_OFF_ENABLE: rdata_d = enable_rd;
      default: rdata_d = 8'h00;
    endcase
    if (!req.rd) begin
      rdata_d = 8'h00;
    end
  end

  // Read data register
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign RDATA_OUT = rdata_q;

  // Assertions
  a_hi_reserved: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (RD_IN && ADDR_IN == TSC_OFF_CH2_HI) |=> RDATA_OUT[7:4] == 4'h0)
    else $error("High byte reserved bits nonzero");
  a_lo_byte: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (RD_IN && ADDR_IN == TSC_OFF_CH3_LO) |=> RDATA_OUT == $past(res[3][7:0]))
    else $error("Low byte mismatch");
  a_full_reset: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (WR_IN && ADDR_IN == TSC_OFF_RESET && WDATA_IN[TSC_BIT_FULL_RESET]) |=> ##1
    (enable_q == TSC_RST_ENABLE && reset_ctl_q == TSC_RST_RESET))
    else $error("Full reset did not restore defaults");
  a_ready_gate: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    !CHIP_READY_OUT |-> !CONVERT_EN_OUT)
    else $error("Conversion while not ready");
  a_hold_stops: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    hold |-> (accept == 4'h0))
    else $error("Conversion accepted during hold");
  a_lowpwr_needs: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (CHAN_LOWPWR_OUT & ~CHAN_ACTIVE_OUT) == 4'h0)
    else $error("Low power without enable");
  a_lowpwr_sel: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (WR_IN && ADDR_IN == TSC_OFF_ENABLE) |=> enable_q[7:4] == $past(WDATA_IN[7:4]))
    else $error("Low power select not stored");
  a_enable_store: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (FOUR_CH && WR_IN && ADDR_IN == TSC_OFF_ENABLE) |=> CHAN_ACTIVE_OUT == $past(WDATA_IN[3:0]))
    else $error("Enable not applied");
  a_two_ch_read: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (!FOUR_CH && RD_IN && ADDR_IN == TSC_OFF_ENABLE) |=> RDATA_OUT[3:0] == 4'h0)
    else $error("Reserved enable bits nonzero");
  a_disabled_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    (!chan_en[2] && !full_reset_q) |=> $stable(res[2]))
    else $error("Disabled channel result changed");
  c_full_reset: cover property (@(posedge REF_CLK_IN) full_reset_q ##[1:300] chip_ready);
  c_hold: cover property (@(posedge REF_CLK_IN) hold ##1 !hold);
  c_conv: cover property (@(posedge REF_CLK_IN) accept[3] && CONV3_IN.valid);
endmodule // tsc_regs

/* File: tsc_pkg.sv */
// Overview of operation
// - Result low byte holds bits 7:0
// - High byte bits 3:0, bits 7:4 zero
// - Channels 2,3 meaningful on four-channel variant only
// - Full-reset bit resets every register to default
// - Operation resumes only after chip-ready reads 1
// - Config-hold bit stops conversions, keeps settings
// - Enable bits 7:4 select low-power channels
// - Low-power needs ordinary enable bit too
// - Enable bits 3:0 enable channels, reset 1
// - Two-channel variant: bits 3:0 read zero
// - Channels 0,1 results at 0x02-0x05
package tsc_pkg;
  // Register offsets
  localparam logic [7:0] TSC_OFF_CH0_LO = 8'h02;
  localparam logic [7:0] TSC_OFF_CH0_HI = 8'h03;
  localparam logic [7:0] TSC_OFF_CH1_LO = 8'h04;
  localparam logic [7:0] TSC_OFF_CH1_HI = 8'h05;
  localparam logic [7:0] TSC_OFF_CH2_LO = 8'h06;
  localparam logic [7:0] TSC_OFF_CH2_HI = 8'h07;
  localparam logic [7:0] TSC_OFF_CH3_LO = 8'h08;
  localparam logic [7:0] TSC_OFF_CH3_HI = 8'h09;
  localparam logic [7:0] TSC_OFF_RESET = 8'h0A;
  localparam logic [7:0] TSC_OFF_ENABLE = 8'h0C;
  localparam logic [7:0] TSC_OFF_STATUS = 8'h00;
  // Field positions
  localparam int TSC_BIT_FULL_RESET = 4;
  localparam int TSC_BIT_CFG_HOLD = 0;
  localparam int TSC_BIT_CHIP_READY = 0;
  // Reset values
  localparam logic [7:0] TSC_RST_RESET = 8'h00;
  localparam logic [7:0] TSC_RST_ENABLE = 8'h1F;
  localparam logic [11:0] TSC_RST_RESULT = 12'h000;
  // Settling time after a full reset before chip-ready
  localparam int TSC_READY_NS = 1000;
  localparam int TSC_CLK_MHZ = 200;
  localparam int TSC_READY_CYC = (TSC_READY_NS * TSC_CLK_MHZ + 999) / 1000;
  // Number of channels
  localparam int TSC_NCH = 4;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsc_req_t;
  // Conversion result from the sensing core
  typedef struct packed {
    logic valid;
    logic [11:0] value;
  } tsc_conv_t;
endpackage

/* File: tsc_result_reg.sv */
`timescale 1ns/1ps
// One channel result holder
module tsc_result_reg
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic accept_in,
  input wire tsc_conv_t conv_in,
  output logic [11:0] result_out
);
  logic [11:0] result_q; // Held result
  logic [11:0] result_d; // Next result
  // Clear on clear_in, else update on accepted valid conversions, else keep
  assign result_d = clear_in ? TSC_RST_RESULT :
                    (accept_in && conv_in.valid) ? conv_in.value : result_q;
  // Result flop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_q <= TSC_RST_RESULT;
    end else begin
      result_q <= result_d;
    end
  end
  assign result_out = result_q;
  a_result_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!clear_in && !(accept_in && conv_in.valid)) |=> $stable(result_q))
    else $error("Result changed without accepted conversion");
endmodule // tsc_result_reg

/* File: tsc_ready_timer.sv */
`timescale 1ns/1ps
// Chip-ready timer after full reset
module tsc_ready_timer
  import tsc_pkg::*;
#(
  parameter int CYCLES = TSC_READY_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  output logic ready_out
);
  logic [15:0] cnt_q; // Remaining cycles
  logic [15:0] cnt_d; // Next count
  assign cnt_d = start_in ? 16'(CYCLES) :
                 (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
  // Countdown, also running after power-up
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 16'(CYCLES);
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign ready_out = (cnt_q == 16'h0000);
endmodule // tsc_ready_timer

/* File: tsc_host.sv */
`timescale 1ns/1ps
// Host side of the register port, one strobe at a time
module tsc_host
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // Idle bus from time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; reserved reset bits always sent as zero
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == TSC_OFF_RESET) ? (d & 8'h11) : d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // One-cycle read; data taken in the following cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
  // Poll chip-ready with a bound, so a dead timer cannot hang us
  task automatic wait_ready(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      rd_reg(TSC_OFF_STATUS, s);
      ok = (s[0] === 1'b1);
    end
  endtask
endmodule // tsc_host

/* File: tsc_regs_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the register bank
module tsc_regs_test;
  import tsc_pkg::*;
  logic ref_clk = 1'b0; // 200 MHz
  logic rstn = 1'b0; // Active-low reset
  logic [7:0] addr, wdata, rdata, d, en_m;
  logic wr, rd, cen, rdy;
  logic [3:0] act, lp;
  tsc_conv_t conv [4]; // Sensing core stand-in
  int res [4]; // Expected results
  int failures = 0;
  int num_checks = 0;
  integer seed = 32'h1FD2FD85;
  bit ok;
  // Clock
  always #2.5 ref_clk = ~ref_clk;
  tsc_host host (.clk_in(ref_clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  // Short ready count keeps the run brief
  tsc_regs #(.FOUR_CH(1'b1), .READY_CYCLES(4)) uut (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .CONV0_IN(conv[0]),
    .CONV1_IN(conv[1]), .CONV2_IN(conv[2]), .CONV3_IN(conv[3]), .RDATA_OUT(rdata),
    .CHAN_ACTIVE_OUT(act), .CHAN_LOWPWR_OUT(lp), .CONVERT_EN_OUT(cen), .CHIP_READY_OUT(rdy));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read both halves of one channel result
  task automatic chk_res(int c);
    logic [7:0] v;
    host.rd_reg(TSC_OFF_CH0_LO + 8'(2 * c), v);
    chk("result low", 8'(res[c]), v);
    host.rd_reg(TSC_OFF_CH0_HI + 8'(2 * c), v);
    chk("result high", {4'h0, 4'(res[c] >> 8)}, v);
  endtask
  // One-cycle conversion pulse; take says whether it should land
  task automatic send(int c, logic [11:0] v, bit take);
    @(posedge ref_clk);
    conv[c] <= {1'b1, v};
    @(posedge ref_clk);
    conv[c] <= '0;
    if (take) res[c] = int'(v);
  endtask
  task automatic give_verdict;
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
  initial begin
    for (int c = 0; c < 4; c++) conv[c] = '0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    host.rd_reg(TSC_OFF_RESET, d);
    chk("reset reg", 8'h00, d);
    host.rd_reg(TSC_OFF_ENABLE, d);
    chk("enable reg", 8'h1F, d);
    for (int c = 0; c < 4; c++) res[c] = 0;
    host.wait_ready(ok);
    chk("chip ready", 8'h01, {7'h00, ok});
    // Random results on every channel
    for (int c = 0; c < 4; c++) begin
      send(c, 12'($random(seed)), 1'b1);
      chk_res(c);
    end
    // Hold first; reserved bits are masked off by the host
    host.wr_reg(TSC_OFF_RESET, 8'hEF);
    host.rd_reg(TSC_OFF_RESET, d);
    chk("reset reg", 8'h01, d);
    chk("convert en", 8'h00, {7'h00, cen});
    send(0, 12'h5A5, 1'b0);
    chk_res(0);
    // Channel 2 off, random low-power picks
    en_m = 8'(($random(seed) & 8'hF0) | 8'h0B);
    host.wr_reg(TSC_OFF_ENABLE, en_m);
    host.wr_reg(TSC_OFF_RESET, 8'h00);
    host.rd_reg(TSC_OFF_ENABLE, d);
    chk("enable reg", en_m, d);
    chk("active", {4'h0, en_m[3:0]}, {4'h0, act});
    chk("low power", {4'h0, en_m[7:4] & en_m[3:0]}, {4'h0, lp});
    send(2, 12'h7FF, 1'b0);
    chk_res(2);
    send(3, 12'h800, 1'b1);
    chk_res(3);
    host.rd_reg(8'h0B, d);
    chk("unmapped", 8'h00, d);
    // Full reset returns every register to default
    host.wr_reg(TSC_OFF_RESET, 8'h10);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ready low", 8'h00, {7'h00, rdy});
    host.rd_reg(TSC_OFF_ENABLE, d);
    chk("enable after", 8'h1F, d);
    for (int c = 0; c < 4; c++) res[c] = 0;
    chk_res(3);
    host.wait_ready(ok);
    chk("ready again", 8'h01, {7'h00, ok});
    give_verdict;
  end
endmodule // tsc_regs_test
